// ==== src/cmsg_defines.vh ====
`ifndef CMSG_DEFINES_VH
`define CMSG_DEFINES_VH
// cpu modes
`define CMSG_MODE_SYS 2'h0
`define CMSG_MODE_USR 2'h1
`define CMSG_MODE_CLF 2'h2
// address map (16-bit cpu address)
`define CMSG_SFR_BASE 16'hFF00
`define CMSG_SFR_CPU_LAST 8'h3F
`define CMSG_SFR_PERI_FIRST 8'h40
`define CMSG_SFR_PERI_LAST 8'h7F
`define CMSG_SFR_MMU_FIRST 8'h80
`define CMSG_SFR_MMU_LAST 8'h9F
`define CMSG_SFR_SEGPTR 8'h80
`define CMSG_SFR_USRMAP 8'h81
`define CMSG_SFR_CLFMAP 8'h82
`define CMSG_SFR_SEGSEL 8'h83
`define CMSG_SFR_SEGLO 8'h84
`define CMSG_SFR_SEGHI 8'h85
`define CMSG_SFR_SEGATTR 8'h86
`define CMSG_SFR_FCD 8'hA0
`define CMSG_SFR_FCD_LAST 8'hAF
// fixed firmware partition
`define CMSG_FW_LO 16'hE000
`define CMSG_FW_HI 16'hEFFF
// segment attribute bits
`define CMSG_ATTR_RD 0
`define CMSG_ATTR_WR 1
`define CMSG_ATTR_EX 2
`define CMSG_ATTR_RESET 3'h0
`define CMSG_SEGPTR_RESET 16'h0000
`define CMSG_MAP_RESET 8'h00
`endif

// ==== src/cmsg_fcd_rom.v ====
`default_nettype none
// factory check data store, loaded while in test mode, registered read
module cmsg_fcd_rom #(
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock
  input wire ref_clk,
  input wire reset,
  input wire clk_en,
  // test-mode load
  input wire test_mode,
  input wire ld_en,
  input wire [AW-1:0] ld_idx,
  input wire [7:0] ld_data,
  // read
  input wire [AW-1:0] rd_idx,
  output reg [7:0] rd_data_reg
);
  reg [7:0] mem [0:DEPTH-1];
  // contents survive reset; only test mode may write
  always @(posedge ref_clk)
  begin
    if (clk_en && test_mode && ld_en)
      mem[ld_idx] <= ld_data;
  end
  always @(posedge ref_clk)
  begin
    if (reset)
      rd_data_reg <= 8'h00;
    else if (clk_en)
      rd_data_reg <= mem[rd_idx];
  end
endmodule // cmsg_fcd_rom
`default_nettype wire

// ==== src/cmsg_guard.v ====
// Functional notes
// R1: segment table pointer writable only in system mode
// R2: mmu registers blocked outside system mode
// R3: peripheral registers open in system mode
// R4: user mode sees only cpu registers after reset; the code also lets user mode read the factory check data (R11)
// R5: user peripheral access only when mmu enables
// R6: reset disables every memory segment
// R7: firmware partition fixed, unchangeable by anyone
// R8: mmu defaults come from hardware reset
// R9: sfr rights hardwired except peripheral maps
// R10: system software configures segments for applications
// R11: factory check data readable in system, user
// R12: denied access suppressed and raises violation
`include "cmsg_defines.vh"
`default_nettype none
module cmsg_guard #(
  parameter NSEG = 8,
  parameter SAW = 3,
  parameter FDEPTH = 16,
  parameter FAW = 4
) (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  input wire clk_en,
  // cpu request
  input wire req,
  input wire req_we,
  input wire req_fetch,
  input wire [1:0] cpu_mode,
  input wire [15:0] req_addr,
  input wire [7:0] req_wdata,
  // test-mode factory data load
  input wire test_mode,
  input wire fcd_ld,
  input wire [FAW-1:0] fcd_idx,
  input wire [7:0] fcd_data,
  // answer to cpu
  output reg grant_reg,
  output reg violation_reg,
  output reg [7:0] rdata_reg,
  output reg rvalid_reg,
  // forwarded access to protected side
  output reg fwd_req_reg,
  output reg fwd_we_reg,
  output reg [15:0] fwd_addr_reg,
  output reg [7:0] fwd_wdata_reg,
  // mmu state visible to memory side
  output reg [15:0] seg_ptr_reg
);
  reg [7:0] usr_map_reg;
  reg [7:0] clf_map_reg;
  reg [SAW-1:0] seg_sel_reg;
  reg [15:0] seg_lo_reg;
  reg [15:0] seg_hi_reg;
  // stage 1 request copy (lookup takes one cycle)
  reg s1_req_reg;
  reg s1_we_reg;
  reg s1_fetch_reg;
  reg [1:0] s1_mode_reg;
  reg [15:0] s1_addr_reg;
  reg [7:0] s1_wdata_reg;
  wire [NSEG-1:0] seg_hit;
  wire [3*NSEG-1:0] seg_attr;
  wire [7:0] fcd_rdata;
  wire seg_wr;
  wire s1_sfr;
  wire [7:0] s1_off;
  reg allow;
  reg seg_ok;
  reg [7:0] sfr_rd;
  integer k;

  // peripheral group index: 8 groups of 8 registers
  function [2:0] cmsg_group;
    input [7:0] off;
    begin
      cmsg_group = off[5:3];
    end
  endfunction

  // inclusive range test used by the firmware partition check
  function cmsg_in;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      cmsg_in = (a >= lo) && (a <= hi);
    end
  endfunction

  assign s1_sfr = s1_addr_reg[15:8] == `CMSG_SFR_BASE >> 8;
  assign s1_off = s1_addr_reg[7:0];
  // segment commit only for allowed system-mode writes
  assign seg_wr = s1_req_reg && s1_we_reg && s1_sfr && allow
    && (s1_off == `CMSG_SFR_SEGATTR);

  cmsg_seg_mem #(.NSEG(NSEG), .AW(SAW)) u_seg (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .wr_en(seg_wr),
    .wr_idx(seg_sel_reg),
    .wr_data({s1_wdata_reg[2:0], seg_hi_reg, seg_lo_reg}),
    .addr(req_addr),
    .hit_reg(seg_hit),
    .attr_reg(seg_attr)
  );

  cmsg_fcd_rom #(.DEPTH(FDEPTH), .AW(FAW)) u_fcd (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .test_mode(test_mode),
    .ld_en(fcd_ld),
    .ld_idx(fcd_idx),
    .ld_data(fcd_data),
    .rd_idx(req_addr[FAW-1:0]),
    .rd_data_reg(fcd_rdata)
  );

  // segment check: any hit segment granting the needed right
  always @*
  begin
    seg_ok = 1'b0;
    for (k = 0; k < NSEG; k = k + 1)
    begin
      if (seg_hit[k])
      begin
        if (s1_fetch_reg && seg_attr[3*k+`CMSG_ATTR_EX])
          seg_ok = 1'b1;
        else if (!s1_fetch_reg && s1_we_reg && seg_attr[3*k+`CMSG_ATTR_WR])
          seg_ok = 1'b1;
        else if (!s1_fetch_reg && !s1_we_reg && seg_attr[3*k+`CMSG_ATTR_RD])
          seg_ok = 1'b1;
      end
    end
  end

  // access decision; sfr rights are fixed logic, only the maps are soft
  always @*
  begin
    allow = 1'b0;
    if (s1_sfr)
    begin
      if (s1_off <= `CMSG_SFR_CPU_LAST)
        allow = 1'b1; // R4
      else if (s1_off >= `CMSG_SFR_PERI_FIRST && s1_off <= `CMSG_SFR_PERI_LAST)
      begin
        case (s1_mode_reg)
          `CMSG_MODE_SYS: allow = 1'b1; // R3
          `CMSG_MODE_USR: allow = usr_map_reg[cmsg_group(s1_off)]; // R5
          `CMSG_MODE_CLF: allow = clf_map_reg[cmsg_group(s1_off)]; // R9
          default: allow = 1'b0;
        endcase
      end
      else if (s1_off >= `CMSG_SFR_MMU_FIRST && s1_off <= `CMSG_SFR_MMU_LAST)
        allow = s1_mode_reg == `CMSG_MODE_SYS; // R2
      else if (s1_off >= `CMSG_SFR_FCD && s1_off <= `CMSG_SFR_FCD_LAST)
        allow = !s1_we_reg && (s1_mode_reg == `CMSG_MODE_SYS
          || s1_mode_reg == `CMSG_MODE_USR); // R11
      else
        allow = 1'b0;
    end
    else if (cmsg_in(s1_addr_reg, `CMSG_FW_LO, `CMSG_FW_HI))
      // partition comes from constants, no register can move it
      allow = s1_mode_reg == `CMSG_MODE_CLF; // R7
    else if (s1_mode_reg == `CMSG_MODE_CLF)
      allow = 1'b0; // R7
    else if (s1_mode_reg == `CMSG_MODE_SYS)
      allow = 1'b1;
    else
      allow = seg_ok; // R6
  end

  // read mux for guard-owned registers
  always @*
  begin
    case (s1_off)
      `CMSG_SFR_SEGPTR: sfr_rd = seg_ptr_reg[7:0];
      `CMSG_SFR_USRMAP: sfr_rd = usr_map_reg;
      `CMSG_SFR_CLFMAP: sfr_rd = clf_map_reg;
      `CMSG_SFR_SEGSEL: sfr_rd = {{(8-SAW){1'b0}}, seg_sel_reg};
      default: sfr_rd = 8'h00;
    endcase
  end

  // request pipeline stage, lined up with the registered lookup
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      s1_req_reg <= 1'b0;
      s1_we_reg <= 1'b0;
      s1_fetch_reg <= 1'b0;
      s1_mode_reg <= `CMSG_MODE_SYS;
      s1_addr_reg <= 16'h0000;
      s1_wdata_reg <= 8'h00;
    end
    else if (clk_en)
    begin
      s1_req_reg <= req;
      s1_we_reg <= req_we;
      s1_fetch_reg <= req_fetch;
      s1_mode_reg <= cpu_mode;
      s1_addr_reg <= req_addr;
      s1_wdata_reg <= req_wdata;
    end
  end

  // mmu registers: reset to restrictive defaults, written only if allowed
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      seg_ptr_reg <= `CMSG_SEGPTR_RESET; // R8
      usr_map_reg <= `CMSG_MAP_RESET; // R4
      clf_map_reg <= `CMSG_MAP_RESET;
      seg_sel_reg <= {SAW{1'b0}};
      seg_lo_reg <= 16'h0000;
      seg_hi_reg <= 16'h0000;
    end
    else if (clk_en && s1_req_reg && s1_we_reg && s1_sfr && allow)
    begin
      case (s1_off)
        // pointer low byte from data; high byte copied from seg_hi_reg low byte
        `CMSG_SFR_SEGPTR: seg_ptr_reg <= {seg_hi_reg[7:0], s1_wdata_reg}; // R1
        `CMSG_SFR_USRMAP: usr_map_reg <= s1_wdata_reg; // R5
        `CMSG_SFR_CLFMAP: clf_map_reg <= s1_wdata_reg; // R9
        `CMSG_SFR_SEGSEL: seg_sel_reg <= s1_wdata_reg[SAW-1:0];
        `CMSG_SFR_SEGLO: seg_lo_reg <= {seg_lo_reg[7:0], s1_wdata_reg};
        `CMSG_SFR_SEGHI: seg_hi_reg <= {seg_hi_reg[7:0], s1_wdata_reg};
        default: seg_ptr_reg <= seg_ptr_reg;
      endcase
    end
  end

  // answer: allowed goes through, denied is dropped and flagged
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      grant_reg <= 1'b0;
      violation_reg <= 1'b0;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      fwd_req_reg <= 1'b0;
      fwd_we_reg <= 1'b0;
      fwd_addr_reg <= 16'h0000;
      fwd_wdata_reg <= 8'h00;
    end
    else if (clk_en)
    begin
      grant_reg <= s1_req_reg && allow;
      violation_reg <= s1_req_reg && !allow; // R12
      rvalid_reg <= s1_req_reg && allow && !s1_we_reg;
      fwd_req_reg <= s1_req_reg && allow; // R12
      fwd_we_reg <= s1_we_reg;
      fwd_addr_reg <= s1_addr_reg;
      fwd_wdata_reg <= s1_wdata_reg;
      if (s1_sfr && s1_off >= `CMSG_SFR_FCD && s1_off <= `CMSG_SFR_FCD_LAST)
        rdata_reg <= (s1_req_reg && allow) ? fcd_rdata : 8'h00;
      else if (s1_sfr && s1_off >= `CMSG_SFR_MMU_FIRST && s1_off <= `CMSG_SFR_MMU_LAST)
        rdata_reg <= (s1_req_reg && allow) ? sfr_rd : 8'h00;
      else
        rdata_reg <= 8'h00;
    end
  end
endmodule // cmsg_guard
`default_nettype wire

// ==== src/cmsg_seg_mem.v ====
`default_nettype none
// segment table: lo, hi bounds and attributes per segment, registered read
module cmsg_seg_mem #(
  parameter NSEG = 8,
  parameter AW = 3
) (
  // clock
  input wire ref_clk,
  input wire reset,
  input wire clk_en,
  // write port
  input wire wr_en,
  input wire [AW-1:0] wr_idx,
  input wire [34:0] wr_data,
  // lookup port
  input wire [15:0] addr,
  output reg [NSEG-1:0] hit_reg,
  output reg [3*NSEG-1:0] attr_reg
);
  reg [15:0] lo_mem [0:NSEG-1];
  reg [15:0] hi_mem [0:NSEG-1];
  reg [2:0] at_mem [0:NSEG-1];
  integer i;
  // reset leaves every segment with no rights at all
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      for (i = 0; i < NSEG; i = i + 1)
      begin
        lo_mem[i] <= 16'hFFFF;
        hi_mem[i] <= 16'h0000;
        at_mem[i] <= `CMSG_ATTR_RESET; // R6
      end
      hit_reg <= {NSEG{1'b0}};
      attr_reg <= {3*NSEG{1'b0}};
    end
    else if (clk_en)
    begin
      if (wr_en)
      begin
        lo_mem[wr_idx] <= wr_data[15:0];
        hi_mem[wr_idx] <= wr_data[31:16];
        at_mem[wr_idx] <= wr_data[34:32];
      end
      for (i = 0; i < NSEG; i = i + 1)
      begin
        hit_reg[i] <= (addr >= lo_mem[i]) && (addr <= hi_mem[i]);
        attr_reg[3*i +: 3] <= at_mem[i];
      end
    end
  end
endmodule // cmsg_seg_mem
`default_nettype wire

// ==== tb/cmsg_chk_sva.sv ====
`include "cmsg_defines.vh"
`default_nettype none
module cmsg_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // cpu request
  input wire logic req,
  input wire logic req_we,
  input wire logic [1:0] cpu_mode,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_wdata,
  // answer side
  input wire logic grant_reg,
  input wire logic violation_reg,
  input wire logic rvalid_reg,
  input wire logic fwd_req_reg,
  input wire logic [15:0] fwd_addr_reg,
  input wire logic [15:0] seg_ptr_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [83:0] pipe_reg;
  wire [27:0] p3 = pipe_reg[55:28];
  wire w3 = p3[26];
  wire [1:0] m3 = p3[25:24];
  wire [15:0] a3 = p3[23:8];
  // request copy lined up with its answer, stalls with clk_en as the guard does
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      pipe_reg <= '0;
    else if (clk_en)
      pipe_reg <= {pipe_reg[55:0], req, req_we, cpu_mode, req_addr, req_wdata};
  end
  default clocking dcb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  answer_delay_a: assert property (
    req && clk_en ##1 clk_en |=> grant_reg ^ violation_reg)
    else $error("request not answered once");
  idle_quiet_a: assert property (!p3[27] |-> !grant_reg && !violation_reg)
    else $error("answer without request");
  deny_fwd_a: assert property (
    violation_reg |-> !fwd_req_reg && !rvalid_reg && $stable(seg_ptr_reg))
    else $error("denied access took effect");
  grant_fwd_a: assert property (grant_reg |-> fwd_req_reg && fwd_addr_reg == a3)
    else $error("granted access not forwarded");
  reset_state_a: assert property ($past(reset) |-> !grant_reg && seg_ptr_reg == 16'h0000)
    else $error("state not cleared by reset");
  ptr_mode_a: assert property (
    !$past(reset) && $changed(seg_ptr_reg)
    |-> grant_reg && w3 && a3 == 16'hFF80 && m3 == `CMSG_MODE_SYS)
    else $error("pointer changed without system write");
  ptr_value_a: assert property (
    grant_reg && w3 && a3 == 16'hFF80 |-> seg_ptr_reg[7:0] == p3[7:0])
    else $error("pointer low byte wrong");
  mmu_sys_a: assert property (
    grant_reg && a3[15:5] == 11'h7FC |-> m3 == `CMSG_MODE_SYS)
    else $error("mmu register open outside system mode");
  part_fixed_a: assert property (
    grant_reg && a3 < 16'hFF00 |-> (a3[15:12] == 4'hE) == (m3 == `CMSG_MODE_CLF))
    else $error("firmware partition crossed");
  fcd_read_a: assert property (
    grant_reg && a3[15:4] == 12'hFFA |-> !w3 && m3 <= `CMSG_MODE_USR)
    else $error("factory data access wrongly granted");
endmodule // cmsg_chk
`default_nettype wire

// ==== tb/cmsg_cpu_model.sv ====
`include "cmsg_defines.vh"
`default_nettype none
module cmsg_cpu_model (
  // clock
  input wire logic ref_clk,
  // request lines
  output logic req,
  output logic req_we,
  output logic req_fetch,
  output logic [1:0] cpu_mode,
  output logic [15:0] req_addr,
  output logic [7:0] req_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // quiet bus at start
  initial
  begin
    {req, req_we, req_fetch, cpu_mode, req_addr, req_wdata} = '0;
  end
  // one access over its taking edge; lines inverted after so stale values never match
  task automatic acc(input logic [1:0] m, input logic we, input logic [15:0] a,
    input logic [7:0] d, input logic fe = 1'b0);
    @(negedge ref_clk);
    {cpu_mode, req_we, req_fetch, req_addr, req_wdata, req} = {m, we, fe, a, d, 1'b1};
    @(negedge ref_clk);
    {req_we, req_fetch, req_addr, req_wdata, req} = {~we, ~fe, ~a, ~d, 1'b0};
  endtask
  // system software opens one segment: select, bounds twice, then commit
  task automatic seg(input logic [2:0] i, input logic [7:0] lo, input logic [7:0] hi,
    input logic [2:0] at);
    acc(`CMSG_MODE_SYS, 1'b1, 16'hFF83, {5'h00, i});
    repeat (2) acc(`CMSG_MODE_SYS, 1'b1, 16'hFF84, lo);
    repeat (2) acc(`CMSG_MODE_SYS, 1'b1, 16'hFF85, hi);
    acc(`CMSG_MODE_SYS, 1'b1, 16'hFF86, {5'h00, at});
  endtask
endmodule // cmsg_cpu_model
`default_nettype wire

// ==== tb/testbench.sv ====
`include "cmsg_defines.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset, clk_en, test_mode, fcd_ld, req, req_we, req_fetch;
  logic grant_reg, violation_reg, rvalid_reg, fwd_req_reg, fwd_we_reg;
  logic [1:0] cpu_mode;
  logic [3:0] fcd_idx;
  logic [7:0] fcd_data, req_wdata, rdata_reg, fwd_wdata_reg;
  logic [15:0] req_addr, fwd_addr_reg, seg_ptr_reg;
  int failures = 0;
  int comparisons = 0;
  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;
  // cpu core on the requesting side
  cmsg_cpu_model cpu (.ref_clk, .req, .req_we, .req_fetch, .cpu_mode, .req_addr, .req_wdata);
  cmsg_guard dut (.ref_clk, .reset, .clk_en, .req, .req_we, .req_fetch, .cpu_mode, .req_addr,
    .req_wdata, .test_mode, .fcd_ld, .fcd_idx, .fcd_data, .grant_reg, .violation_reg,
    .rdata_reg, .rvalid_reg, .fwd_req_reg, .fwd_we_reg, .fwd_addr_reg, .fwd_wdata_reg,
    .seg_ptr_reg);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one access, answer sampled in its single valid cycle
  task automatic acc_chk(input logic [1:0] m, input logic we, input logic [15:0] a,
    input logic [7:0] d, input logic g, input logic [7:0] rd, input logic fe);
    cpu.acc(m, we, a, d, fe);
    // answer registers one edge after the stage copy, stands one cycle
    @(negedge ref_clk);
    check(grant_reg, g);
    check(violation_reg, !g);
    check(fwd_req_reg, g);
    check(rvalid_reg, g && !we);
    if (g && !we)
      check(rdata_reg, rd);
  endtask
  // same access in system, user and firmware mode; g bit per mode
  task automatic probe(input logic we, input logic [15:0] a, input logic [7:0] d,
    input logic [2:0] g, input logic [7:0] rd = 8'h00, input logic fe = 1'b0);
    for (int m = `CMSG_MODE_SYS; m <= `CMSG_MODE_CLF; m++)
      acc_chk(m[1:0], we, a, d, g[m], rd, fe);
  endtask
  task automatic sc_reset;
    reset = 1'b1;
    repeat (4) @(negedge ref_clk);
    reset = 1'b0;
    check(grant_reg, 1'b0);
    check(seg_ptr_reg, `CMSG_SEGPTR_RESET);
    probe(1'b0, 16'hFF48, 8'h00, 3'h1);
    probe(1'b0, 16'hFF10, 8'h00, 3'h7);
  endtask
  task automatic sc_ptr;
    repeat (2) probe(1'b1, 16'hFF85, 8'h12, 3'h1);
    probe(1'b1, 16'hFF80, 8'h34, 3'h1);
    check(seg_ptr_reg, 16'h1234);
    probe(1'b0, 16'hFF81, 8'h00, 3'h1);
  endtask
  task automatic sc_sfr;
    acc_chk(`CMSG_MODE_SYS, 1'b1, 16'hFF81, 8'h02, 1'b1, 8'h00, 1'b0);
    acc_chk(`CMSG_MODE_SYS, 1'b1, 16'hFF82, 8'h04, 1'b1, 8'h00, 1'b0);
    probe(1'b0, 16'hFF48, 8'h00, 3'h3);
    probe(1'b1, 16'hFF50, 8'h00, 3'h5);
    probe(1'b0, 16'hFF81, 8'h00, 3'h1, 8'h02);
    probe(1'b0, 16'hFFC0, 8'h00, 3'h0);
  endtask
  task automatic sc_seg;
    probe(1'b0, 16'h1800, 8'h00, 3'h1);
    cpu.seg(3'h0, 8'h10, 8'h1F, 3'h1);
    repeat (4) @(negedge ref_clk);
    probe(1'b0, 16'h1800, 8'h00, 3'h3);
    probe(1'b1, 16'h1800, 8'h00, 3'h1);
    probe(1'b0, 16'h1800, 8'h00, 3'h1, 8'h00, 1'b1);
    probe(1'b0, 16'h2000, 8'h00, 3'h1);
  endtask
  task automatic sc_part;
    cpu.seg(3'h1, 8'hE0, 8'hEF, 3'h7);
    repeat (4) @(negedge ref_clk);
    probe(1'b0, 16'hE800, 8'h00, 3'h4);
    probe(1'b1, 16'hEFFF, 8'h00, 3'h4);
    probe(1'b0, 16'hF000, 8'h00, 3'h1);
  endtask
  task automatic sc_fcd;
    @(negedge ref_clk);
    {test_mode, fcd_ld, fcd_idx, fcd_data} = {1'b1, 1'b1, 4'h3, 8'hA5};
    @(negedge ref_clk);
    {test_mode, fcd_ld} = 2'h0;
    probe(1'b0, 16'hFFA3, 8'h00, 3'h3, 8'hA5);
    probe(1'b1, 16'hFFA3, 8'h00, 3'h0);
  endtask
  // main sequence, with a second reset after the maps were opened
  initial
  begin
    {reset, clk_en, test_mode, fcd_ld, fcd_idx, fcd_data} = {2'h3, 14'h0000};
    sc_reset;
    sc_ptr;
    sc_sfr;
    sc_reset;
    sc_seg;
    sc_part;
    sc_fcd;
    results;
  end
endmodule // testbench
bind cmsg_guard cmsg_chk chk (.ref_clk, .reset, .clk_en, .req, .req_we, .cpu_mode, .req_addr,
  .req_wdata, .grant_reg, .violation_reg, .rvalid_reg, .fwd_req_reg, .fwd_addr_reg,
  .seg_ptr_reg);
`default_nettype wire
